// ---- hdl/hsss_pkg.sv ----
// Shared constants, register map and state encoding of the hot-swap supply sequencer
package hsss_pkg;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_MHZ = 250;
	localparam int BSEL_FILTER_US = 100;
	localparam int BSEL_FILTER_CYC_DFLT = BSEL_FILTER_US * CLK_MHZ;
	localparam int FAULT_FILTER_NS = 1000;
	localparam int FAULT_FILTER_CYC_DFLT = (FAULT_FILTER_NS * CLK_MHZ + 999) / 1000;
	localparam int CLAMP_US = 500;
	localparam int CLAMP_CYC_DFLT = CLAMP_US * CLK_MHZ;

	// ------------------------------------------------------------
	// Channels and pulses
	// ------------------------------------------------------------
	localparam int NUM_CH = 4;
	localparam logic [2:0] CH_FIRST = 3'h0;
	localparam logic [2:0] CH_TOP = 3'h3;
	localparam logic [2:0] LAST_PULSE = 3'h4;
	localparam logic [3:0] DRIVE_CH1 = 4'h1;

	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam int WB_ADR_W = 8;
	localparam logic [WB_ADR_W-1:0] REG_CTRL = 8'h00;
	localparam logic [WB_ADR_W-1:0] REG_STATUS = 8'h04;
	localparam logic [WB_ADR_W-1:0] REG_CAUSE = 8'h08;
	localparam int CTRL_EN_BIT = 0;
	localparam logic CTRL_EN_RST = 1'b1;

	// ------------------------------------------------------------
	// Sequencer states, Gray along the turn-on path
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_RISE = 3'h1,
		ST_FALL = 3'h3,
		ST_GOOD = 3'h2,
		ST_SHUT_RISE = 3'h6,
		ST_SHUT_FALL = 3'h7,
		ST_FAULT = 3'h4
	} hsss_state_t;

endpackage

// ---- hdl/hsss_persist_filter.sv ----
// Per-bit persistence filter: output follows input only after a steady run
`timescale 1ns/10ps
module hsss_persist_filter #(
	parameter int WIDTH = 1,
	parameter int COUNT = 1,
	parameter logic [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [WIDTH-1:0] raw_i,
	output wire logic [WIDTH-1:0] filt_o
);

	localparam int CW = $clog2(COUNT + 1);

	generate
		if (COUNT < 1 || WIDTH < 1) begin : g_bad
			$error("hsss_persist_filter: COUNT and WIDTH must be at least 1");
		end
	endgenerate

	// ------------------------------------------------------------
	// One counter per bit; any glitch back restarts the run
	// ------------------------------------------------------------
	genvar b;
	generate
		for (b = 0; b < WIDTH; b++) begin : g_bit
			logic [CW-1:0] cnt_q;
			logic filt_q;
			wire differs = raw_i[b] != filt_q;
			wire done = cnt_q == CW'(COUNT - 1);
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					cnt_q <= '0;
					filt_q <= RST_VAL[b];
				end else if (differs && done) begin
					cnt_q <= '0;
					filt_q <= raw_i[b];
				end else if (differs) begin
					cnt_q <= cnt_q + CW'(1);
				end else begin
					cnt_q <= '0;
				end
			end
			assign filt_o[b] = filt_q;
		end
	endgenerate

endmodule

// ---- hdl/hsss_sequencer.sv ----
// Turn-on, turn-off and fault latch sequencer for four hot-swap rails
//
// Added by the designer: the address map and the Wishbone register port.
`timescale 1ns/10ps

module hsss_sequencer
	import hsss_pkg::*;
#(
	parameter int BSEL_FILTER_CYC = BSEL_FILTER_CYC_DFLT,
	parameter int FAULT_FILTER_CYC = FAULT_FILTER_CYC_DFLT,
	parameter int CLAMP_CYC = CLAMP_CYC_DFLT
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [WB_ADR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic board_select_n_i,
	input wire logic [NUM_CH-1:0] rail_supply_ok_i,
	input wire logic [NUM_CH-1:0] voltage_window_fault_i,
	input wire logic [NUM_CH-1:0] overcurrent_i,
	input wire logic [NUM_CH-1:0] rail_discharged_i,
	input wire logic ramp_upper_i,
	input wire logic ramp_lower_i,
	input wire logic ramp_peak_i,
	output logic [NUM_CH-1:0] pass_switch_drive_o,
	output logic [NUM_CH-1:0] fault_monitor_en_o,
	output logic ramp_charge_o,
	output logic ramp_discharge_o,
	output logic ramp_fast_o,
	output logic ramp_clamp_o,
	output logic peak_current_limit_sel_o,
	output logic power_good_n_o,
	output logic fault_latched_o
);

	localparam int CLW = $clog2(CLAMP_CYC + 1);

	generate
		if (NUM_CH != 4 || CLAMP_CYC < 1 || BSEL_FILTER_CYC < 1 || FAULT_FILTER_CYC < 1) begin : g_bad
			$error("hsss_sequencer: four channels and non-zero timing counts required");
		end
	endgenerate

	// ------------------------------------------------------------
	// Input filters
	// ------------------------------------------------------------
	logic sel_n_f;
	logic [2*NUM_CH-1:0] flt_f;

	hsss_persist_filter #(.WIDTH(1), .COUNT(BSEL_FILTER_CYC), .RST_VAL(1'b1)) u_sel_filt (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.raw_i(board_select_n_i),
		.filt_o(sel_n_f)
	);

	hsss_persist_filter #(.WIDTH(2*NUM_CH), .COUNT(FAULT_FILTER_CYC)) u_flt_filt (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.raw_i({overcurrent_i, voltage_window_fault_i}),
		.filt_o(flt_f)
	);

	// ------------------------------------------------------------
	// State and register declarations
	// ------------------------------------------------------------
	hsss_state_t state_q, state_d;
	logic [2:0] ch_q, ch_d;
	logic [NUM_CH-1:0] drive_q, drive_d;
	logic [NUM_CH-1:0] mon_q, mon_d;
	logic pg_n_q, pg_n_d;
	logic charge_q, discharge_q, fast_q, clamp_q, peak_q;
	logic fault_q;
	logic [CLW-1:0] clamp_cnt_q, clamp_cnt_d;
	logic [NUM_CH-1:0] cause_q;
	logic ctrl_en_q;
	logic [31:0] rdata_q;
	logic ack_q;

	// ------------------------------------------------------------
	// Fault and sequence decode
	// ------------------------------------------------------------
	wire [NUM_CH-1:0] volt_flt = flt_f[NUM_CH-1:0] & mon_q;
	wire [NUM_CH-1:0] oc_flt = flt_f[2*NUM_CH-1:NUM_CH] & drive_q;
	wire [NUM_CH-1:0] fault_vec = volt_flt | oc_flt;
	wire fault_hit = |fault_vec;
	wire powered = state_q != ST_IDLE && state_q != ST_FAULT;
	wire all_ok = &rail_supply_ok_i;
	wire start_ok = !sel_n_f && all_ok && ctrl_en_q;
	wire ch_is_last = ch_q == LAST_PULSE;
	wire [1:0] ch_lo = ch_q[1:0];
	wire [2:0] ch_up = ch_q + 3'h1;
	wire [2:0] ch_dn = ch_is_last ? CH_TOP : ch_q - 3'h1;
	// Channel 4 load is not watched on the way down; it only waits for the pulse
	wire shut_step_ok = ramp_lower_i && (ch_is_last || ch_q == CH_TOP || rail_discharged_i[ch_lo]);

	// ------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------
	always_comb begin
		state_d = state_q;
		ch_d = ch_q;
		drive_d = drive_q;
		mon_d = mon_q;
		pg_n_d = pg_n_q;
		unique case (state_q)
			ST_IDLE: begin
				drive_d = '0;
				mon_d = '0;
				pg_n_d = 1'b1;
				if (start_ok) begin
					state_d = ST_RISE;
					ch_d = CH_FIRST;
					drive_d = DRIVE_CH1;
				end
			end
			ST_RISE: begin
				if (sel_n_f) begin
					state_d = ST_IDLE;
					drive_d = '0;
					mon_d = '0;
				end else if (ramp_upper_i) begin
					state_d = ST_FALL;
				end
			end
			ST_FALL: begin
				if (sel_n_f) begin
					state_d = ST_IDLE;
					drive_d = '0;
					mon_d = '0;
				end else if (ramp_lower_i && ch_is_last) begin
					state_d = ST_GOOD;
					pg_n_d = 1'b0;
				end else if (ramp_lower_i) begin
					state_d = ST_RISE;
					ch_d = ch_up;
					mon_d[ch_lo] = 1'b1;
					if (ch_q < CH_TOP) begin
						drive_d[ch_lo + 2'h1] = 1'b1;
					end
				end
			end
			ST_GOOD: begin
				if (sel_n_f) begin
					state_d = ST_SHUT_RISE;
					pg_n_d = 1'b1;
					ch_d = LAST_PULSE;
					mon_d[CH_TOP[1:0]] = 1'b0;
				end
			end
			ST_SHUT_RISE: begin
				if (ramp_upper_i) begin
					state_d = ST_SHUT_FALL;
				end
			end
			ST_SHUT_FALL: begin
				if (shut_step_ok) begin
					if (!ch_is_last) begin
						drive_d[ch_lo] = 1'b0;
					end
					if (ch_q == CH_FIRST) begin
						state_d = ST_IDLE;
					end else begin
						state_d = ST_SHUT_RISE;
						ch_d = ch_dn;
						if (ch_dn != CH_FIRST) begin
							mon_d[ch_dn[1:0] - 2'h1] = 1'b0;
						end
					end
				end
			end
			ST_FAULT: begin
				drive_d = '0;
				mon_d = '0;
				pg_n_d = 1'b1;
				if (sel_n_f) begin
					state_d = ST_IDLE;
				end
			end
		endcase
		if (powered && fault_hit) begin
			state_d = ST_FAULT;
			drive_d = '0;
			mon_d = '0;
			pg_n_d = 1'b1;
		end
	end

	// Clamp timer restarts on every turn-on ramp pulse of a real rail
	wire entering_rise = state_d == ST_RISE && state_q != ST_RISE;
	always_comb begin
		clamp_cnt_d = '0;
		if (entering_rise && ch_d != LAST_PULSE) begin
			clamp_cnt_d = CLW'(CLAMP_CYC);
		end else if (state_d == ST_RISE && clamp_cnt_q != '0) begin
			clamp_cnt_d = clamp_cnt_q - CLW'(1);
		end
	end

	wire pulse_state_d = state_d inside {ST_RISE, ST_FALL, ST_SHUT_RISE, ST_SHUT_FALL};
	wire charge_d = state_d == ST_RISE || state_d == ST_SHUT_RISE;
	wire discharge_d = state_d == ST_FALL || state_d == ST_SHUT_FALL;
	wire fast_d = (pulse_state_d && ch_d == LAST_PULSE) || state_d == ST_SHUT_RISE;
	wire clamp_d = state_d == ST_RISE && clamp_cnt_d != '0;
	// Peak reference stays once the slope reaches it within a turn-on pulse
	wire peak_d = discharge_d || (state_d == ST_RISE && state_q == ST_RISE && (peak_q || ramp_peak_i));

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_q <= ST_IDLE;
			ch_q <= CH_FIRST;
			drive_q <= '0;
			mon_q <= '0;
			pg_n_q <= 1'b1;
			charge_q <= 1'b0;
			discharge_q <= 1'b0;
			fast_q <= 1'b0;
			clamp_q <= 1'b0;
			peak_q <= 1'b0;
			fault_q <= 1'b0;
			clamp_cnt_q <= '0;
		end else begin
			state_q <= state_d;
			ch_q <= ch_d;
			drive_q <= drive_d;
			mon_q <= mon_d;
			pg_n_q <= pg_n_d;
			charge_q <= charge_d;
			discharge_q <= discharge_d;
			fast_q <= fast_d;
			clamp_q <= clamp_d;
			peak_q <= peak_d;
			fault_q <= state_d == ST_FAULT;
			clamp_cnt_q <= clamp_cnt_d;
		end
	end

	// Cause holds the channels that tripped until the latch is released
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cause_q <= '0;
		end else if (powered && fault_hit) begin
			cause_q <= fault_vec;
		end else if (state_q == ST_FAULT && sel_n_f) begin
			cause_q <= '0;
		end
	end

	// ------------------------------------------------------------
	// Wishbone slave, one wait state, unmapped reads as zero
	// ------------------------------------------------------------
	wire wb_req = wb_cyc_i && wb_stb_i && !ack_q;
	wire hit_ctrl = wb_adr_i == REG_CTRL;
	wire hit_status = wb_adr_i == REG_STATUS;
	wire hit_cause = wb_adr_i == REG_CAUSE;
	wire ctrl_wr = wb_req && wb_we_i && hit_ctrl && wb_sel_i[0];
	wire [31:0] ctrl_word = {31'h0, ctrl_en_q};
	wire [31:0] status_word = {13'h0, sel_n_f, state_q == ST_FAULT, pg_n_q, mon_q, drive_q, 1'b0, ch_q, 1'b0, state_q};
	wire [31:0] cause_word = {28'h0, cause_q};
	wire [31:0] rdata_d = hit_ctrl ? ctrl_word : hit_status ? status_word : hit_cause ? cause_word : 32'h0;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
			rdata_q <= 32'h0;
			ctrl_en_q <= CTRL_EN_RST;
		end else begin
			ack_q <= wb_req;
			rdata_q <= (wb_req && !wb_we_i) ? rdata_d : 32'h0;
			if (ctrl_wr) begin
				ctrl_en_q <= wb_dat_i[CTRL_EN_BIT];
			end
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign wb_ack_o = ack_q;
	assign wb_dat_o = rdata_q;
	assign pass_switch_drive_o = drive_q;
	assign fault_monitor_en_o = mon_q;
	assign ramp_charge_o = charge_q;
	assign ramp_discharge_o = discharge_q;
	assign ramp_fast_o = fast_q;
	assign ramp_clamp_o = clamp_q;
	assign peak_current_limit_sel_o = peak_q;
	assign power_good_n_o = pg_n_q;
	assign fault_latched_o = fault_q;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	property p_no_start_out_of_window;
		@(posedge clk_i) disable iff (rst_i) (state_q == ST_IDLE && !all_ok) |=> (state_q == ST_IDLE && drive_q == '0);
	endproperty
	a_no_start_out_of_window: assert property (p_no_start_out_of_window) else $error("rail started with supply out of window");

	property p_start_ch1;
		@(posedge clk_i) disable iff (rst_i) (state_q == ST_IDLE && start_ok) |=> (state_q == ST_RISE && drive_q == DRIVE_CH1 && charge_q);
	endproperty
	a_start_ch1: assert property (p_start_ch1) else $error("turn-on did not start on channel 1");

	property p_rise_to_fall;
		@(posedge clk_i) disable iff (rst_i) (state_q == ST_RISE && ramp_upper_i && !sel_n_f && !fault_hit) |=> (state_q == ST_FALL && discharge_q && !charge_q && peak_q);
	endproperty
	a_rise_to_fall: assert property (p_rise_to_fall) else $error("upper threshold did not start discharge");

	property p_advance;
		@(posedge clk_i) disable iff (rst_i) (state_q == ST_FALL && ramp_lower_i && !ch_is_last && !sel_n_f && !fault_hit)
			|=> (state_q == ST_RISE && ch_q == $past(ch_q) + 3'h1 && mon_q[$past(ch_lo)]);
	endproperty
	a_advance: assert property (p_advance) else $error("pulse end did not advance and arm monitoring");

	property p_fault_off;
		@(posedge clk_i) disable iff (rst_i) (powered && fault_hit) |=> (drive_q == '0 && pg_n_q && state_q == ST_FAULT) [*2];
	endproperty
	a_fault_off: assert property (p_fault_off) else $error("fault did not shut all rails");

	property p_fault_latched;
		@(posedge clk_i) disable iff (rst_i) (state_q == ST_FAULT && !sel_n_f) |=> state_q == ST_FAULT;
	endproperty
	a_fault_latched: assert property (p_fault_latched) else $error("fault latch released while selected");

	property p_fifth_fast;
		@(posedge clk_i) disable iff (rst_i) (state_q inside {ST_RISE, ST_FALL} && ch_is_last) |-> (ramp_fast_o && drive_q == 4'hF && !clamp_q);
	endproperty
	a_fifth_fast: assert property (p_fifth_fast) else $error("fifth pulse not fast");

	property p_power_good;
		@(posedge clk_i) disable iff (rst_i) $fell(pg_n_q) |-> ($past(state_q) == ST_FALL && $past(ch_q) == LAST_PULSE && mon_q == 4'hF);
	endproperty
	a_power_good: assert property (p_power_good) else $error("power-good asserted early");

	property p_clamp_first;
		@(posedge clk_i) disable iff (rst_i) (state_q != ST_RISE ##1 state_q == ST_RISE && !ch_is_last) |-> clamp_q;
	endproperty
	a_clamp_first: assert property (p_clamp_first) else $error("rail pulse began unclamped");

	property p_reverse_off;
		@(posedge clk_i) disable iff (rst_i) (state_q == ST_SHUT_FALL && shut_step_ok && !ch_is_last && !fault_hit)
			|=> (drive_q[$past(ch_lo)] == 1'b0 && pg_n_q);
	endproperty
	a_reverse_off: assert property (p_reverse_off) else $error("shutdown step left channel on");

endmodule

// ---- tb/hsss_backplane.sv ----
// Partner models: backplane select driver and ramp timing node comparators
`timescale 1ns/10ps

// ------------------------------------------------------------
// Backplane select driver
// ------------------------------------------------------------
module hsss_backplane (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic select_req_i,
	output logic board_select_n_o
);
	// Pull-up holds select high while the backplane is not asserting it
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			board_select_n_o <= 1'b1;
		end else begin
			board_select_n_o <= ~select_req_i;
		end
	end
endmodule

// ------------------------------------------------------------
// Ramp capacitor with upper, peak and lower comparators
// ------------------------------------------------------------
module hsss_ramp_model (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic charge_i,
	input wire logic discharge_i,
	input wire logic fast_i,
	output logic upper_o,
	output logic lower_o,
	output logic peak_o
);
	logic [4:0] lvl_q;
	// Fast current moves four steps a cycle, so the fifth pulse is short
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			lvl_q <= 5'h00;
		end else if (charge_i && lvl_q < 5'h10) begin
			lvl_q <= lvl_q + (fast_i ? 5'h04 : 5'h01);
		end else if (discharge_i && lvl_q != 5'h00) begin
			lvl_q <= lvl_q - (fast_i ? 5'h04 : 5'h01);
		end
	end
	assign upper_o = lvl_q >= 5'h10;
	assign peak_o = lvl_q >= 5'h0E;
	assign lower_o = lvl_q == 5'h00;
endmodule

// ---- tb/hot_swap_supply_sequencer_test.sv ----
// Self-checking testbench of the hot-swap supply sequencer
`timescale 1ns/10ps
module hot_swap_supply_sequencer_test;
	import hsss_pkg::*;
	logic clk_i, rst_i, cyc, stb, we, ack, bsel_n, want;
	logic [7:0] adr;
	logic [3:0] sel, drv, mon, vflt, dischg;
	logic [31:0] wdat, rdat, r;
	logic chg, dis, fast, clamp, peak, pg_n, flt, up, low, pk;
	// Channel order 12 V, 5 V, 3.3 V, -12 V on bits 0..3
	logic [3:0] supply_ok;
	logic [3:0] drv_tab [5] = '{4'h1, 4'h3, 4'h7, 4'hF, 4'hF};
	// Fifth pulse arms channel 4 as it starts
	logic [3:0] mon_tab [5] = '{4'h0, 4'h1, 4'h3, 4'h7, 4'hF};
	int n_errors = 0, num_checks = 0, cycles = 0;

	hsss_sequencer #(.BSEL_FILTER_CYC(4), .FAULT_FILTER_CYC(2), .CLAMP_CYC(5)) i_dut (
		.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .board_select_n_i(bsel_n),
		.rail_supply_ok_i(supply_ok), .voltage_window_fault_i(vflt), .overcurrent_i(4'h0),
		.rail_discharged_i(dischg), .ramp_upper_i(up), .ramp_lower_i(low), .ramp_peak_i(pk),
		.pass_switch_drive_o(drv), .fault_monitor_en_o(mon), .ramp_charge_o(chg), .ramp_discharge_o(dis),
		.ramp_fast_o(fast), .ramp_clamp_o(clamp), .peak_current_limit_sel_o(peak), .power_good_n_o(pg_n),
		.fault_latched_o(flt));
	hsss_backplane i_bp (.clk_i(clk_i), .rst_i(rst_i), .select_req_i(want), .board_select_n_o(bsel_n));
	hsss_ramp_model i_ramp (.clk_i(clk_i), .rst_i(rst_i), .charge_i(chg), .discharge_i(dis), .fast_i(fast),
		.upper_o(up), .lower_o(low), .peak_o(pk));

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task step;
		@(posedge clk_i);
		#1;
	endtask
	task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// Request stays put until ack is sampled high at an edge
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge clk_i);
		cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= 4'hF;
		do @(posedge clk_i); while (ack !== 1'b1);
		q = rdat;
		cyc <= 1'b0; stb <= 1'b0; we <= 1'b0; sel <= 4'h0;
	endtask
	task select(input logic v);
		@(posedge clk_i);
		want <= v;
	endtask
	task give_verdict;
		$display("checks %0d mismatches %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task t_regs;
		check("drive after reset", drv, 4'h0);
		check("pg_n after reset", pg_n, 1'b1);
		wb(1'b0, REG_CTRL, 32'h0, r);
		check("ctrl reset", r[0], CTRL_EN_RST);
		wb(1'b0, 8'h40, 32'h0, r);
		check("unmapped read", r, 32'h0);
		wb(1'b1, REG_CTRL, 32'h0, r);
		wb(1'b0, REG_CTRL, 32'h0, r);
		check("ctrl written", r[0], 1'b0);
		select(1'b1);
		repeat (30) step;
		check("drive while disabled", drv, 4'h0);
		select(1'b0);
		repeat (12) step;
		wb(1'b1, REG_CTRL, 32'h1, r);
		$display("register test done");
	endtask
	task t_supply;
		@(posedge clk_i);
		supply_ok <= 4'hB;
		select(1'b1);
		repeat (30) step;
		check("drive with supply out", drv, 4'h0);
		select(1'b0);
		repeat (12) step;
		supply_ok <= 4'hF;
		$display("supply window test done");
	endtask
	task t_turn_on;
		// A select shorter than the filter must not start anything
		select(1'b1);
		select(1'b0);
		repeat (15) step;
		check("drive after glitch", drv, 4'h0);
		select(1'b1);
		for (int k = 0; k < 5; k++) begin
			for (int i = 0; i < 300 && chg !== 1'b1; i++) step;
			check("pulse drive", drv, drv_tab[k]);
			check("pulse monitor", mon, mon_tab[k]);
			check("pulse clamp", clamp, k < 4);
			check("pulse fast", fast, k == 4);
			for (int i = 0; i < 300 && dis !== 1'b1; i++) step;
			check("fall peak", peak, 1'b1);
			check("fall charge", chg, 1'b0);
		end
		for (int i = 0; i < 300 && pg_n !== 1'b0; i++) step;
		check("power good", pg_n, 1'b0);
		check("all armed", mon, 4'hF);
		wb(1'b0, REG_STATUS, 32'h0, r);
		check("status state", r[2:0], ST_GOOD);
		$display("turn-on test done");
	endtask
	task t_shutdown;
		logic [3:0] prev;
		logic [3:0] order [4] = '{4'h7, 4'h3, 4'h1, 4'h0};
		select(1'b0);
		for (int i = 0; i < 300 && pg_n !== 1'b1; i++) step;
		check("pg released first", drv, 4'hF);
		for (int j = 0; j < 4; j++) begin
			prev = drv;
			for (int i = 0; i < 500 && drv === prev; i++) step;
			check("reverse order", drv, order[j]);
		end
		$display("shutdown test done");
	endtask
	task t_fault;
		select(1'b1);
		for (int i = 0; i < 500 && mon[0] !== 1'b1; i++) step;
		@(posedge clk_i);
		vflt <= 4'h1;
		@(posedge clk_i);
		vflt <= 4'h0;
		repeat (6) step;
		check("short fault ignored", flt, 1'b0);
		@(posedge clk_i);
		vflt <= 4'h1;
		for (int i = 0; i < 50 && flt !== 1'b1; i++) step;
		check("fault latched", flt, 1'b1);
		check("fault drive off", drv, 4'h0);
		check("fault pg", pg_n, 1'b1);
		vflt <= 4'h0;
		repeat (20) step;
		check("latch holds", flt, 1'b1);
		wb(1'b0, REG_CAUSE, 32'h0, r);
		check("cause", r[3:0], 4'h1);
		select(1'b0);
		for (int i = 0; i < 50 && flt !== 1'b0; i++) step;
		check("latch cleared", flt, 1'b0);
		select(1'b1);
		for (int i = 0; i < 50 && drv === 4'h0; i++) step;
		check("restart", drv, 4'h1);
		select(1'b0);
		for (int i = 0; i < 50 && drv !== 4'h0; i++) step;
		check("abort on deselect", drv, 4'h0);
		$display("fault test done");
	endtask

	// ------------------------------------------------------------
	// Clock, timeout and main sequence
	// ------------------------------------------------------------
	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end
	// A hung wait ends here; the whole run needs a few hundred cycles
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			n_errors++;
			give_verdict();
		end
	end
	initial begin
		rst_i = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h00; sel = 4'h0; wdat = 32'h0;
		want = 1'b0; supply_ok = 4'hF; vflt = 4'h0; dischg = 4'hF;
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		step;
		t_regs();
		t_supply();
		t_turn_on();
		t_shutdown();
		t_fault();
		give_verdict();
	end
endmodule
